// file: verilog/servo_pid_position_loop.sv
// Per-axis servo position loop: trajectory generator, PID filter with feed forward,
// deadband compensation and following error trip, driving a signed DAC code.
// Assumes the encoder counter and the DAC sit outside on the same clock; the
// amplifier enable and command are registered outputs.
//
// Added by the designer: the register addresses and strobed register access.

// Overview of operation
// RL1 - Run the whole filter once every 250 us, one new command per sample.
// RL2 - Following error is desired position minus measured encoder position.
// RL3 - Drive the +/-10 V command in the direction that reduces the error.
// RL4 - Build the desired profile from max velocity, acceleration and deceleration.
// RL5 - Add velocity feed forward proportional to commanded trajectory velocity.
// RL6 - While ramping, add commanded acceleration times acceleration or deceleration gain.
// RL7 - In integral zero mode, integrate only after the trajectory has finished.
// RL8 - Add deadband to positive outputs, subtract it from negative outputs.
// RL9 - Error beyond the limit disables the axis, amplifier off, output zero, flag set.
// RL10 - A zero limit disables the check; re-enabling clears the latched error (the code leaves the status flag set until it is written).
// RL11 - Command is P, I, D plus feed forward, saturated at the output range.
// RL12 - Clear the integral accumulator whenever the axis is disabled.
module servo_pid_position_loop (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    output logic      [31:0] reg_rdata_o,
    input  wire logic [31:0] encoder_pos_i,
    output logic      [15:0] dac_command_o,
    output logic             amp_enable_o,
    output logic             irq_o
);

    localparam int unsigned PW = servo_loop_pkg::POS_W;
    localparam int unsigned AW = servo_loop_pkg::ACC_W;

    function automatic logic signed [AW-1:0] scale_gain(input logic signed [PW-1:0] x,
                                                        input logic [31:0] g);
        logic signed [AW+16:0] prod;
        prod = $signed({{(AW-PW){x[PW-1]}}, x}) * $signed({1'b0, g[15:0]});
        return AW'(prod >>> servo_loop_pkg::GAIN_FRAC);
    endfunction : scale_gain

    function automatic logic signed [AW-1:0] clamp_out(input logic signed [AW-1:0] v);
        if (v > AW'(servo_loop_pkg::DAC_MAX))
        begin
            return AW'(servo_loop_pkg::DAC_MAX);
        end
        if (v < AW'(servo_loop_pkg::DAC_MIN))
        begin
            return AW'(servo_loop_pkg::DAC_MIN);
        end
        return v;
    endfunction : clamp_out

    // Registers and state.
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] kp_q, kp_d, ki_q, ki_d, kd_q, kd_d;
    logic [31:0] kvff_q, kvff_d, kaff_q, kaff_d, kdff_q, kdff_d;
    logic [31:0] deadband_q, deadband_d, fe_limit_q, fe_limit_d;
    logic [31:0] max_vel_q, max_vel_d, accel_q, accel_d, decel_q, decel_d;
    logic [31:0] target_q, target_d;
    logic [servo_loop_pkg::EVT_W-1:0] evt_q, evt_d, mask_q, mask_d;
    logic [31:0] rdata_q, rdata_d;
    logic        enabled_q, enabled_d;
    logic [servo_loop_pkg::SAMPLE_CNT_W-1:0] tick_cnt_q, tick_cnt_d;
    servo_loop_pkg::prof_state_e prof_q, prof_d;
    logic signed [PW-1:0] desired_q, desired_d, vel_q, vel_d, acc_cmd_q, acc_cmd_d;
    logic signed [PW-1:0] ferr_q, ferr_d;
    logic signed [AW-1:0] integ_q, integ_d, out_q, out_d;
    logic [15:0] dac_q, dac_d;
    logic        irq_q, irq_d;

    logic        tick;
    logic        move_start;
    logic signed [PW-1:0] remain, stop_dist, ferr_now, abs_ferr, dir;
    logic signed [AW-1:0] pid_sum, comp;

    assign tick = (tick_cnt_q == servo_loop_pkg::SAMPLE_CNT_W'(servo_loop_pkg::SAMPLE_CYCLES - 1));
    assign move_start = reg_write_i && (reg_addr_i == servo_loop_pkg::REG_TARGET);

    // Register bus and interrupt logic.
    always_comb
    begin
        ctrl_d = ctrl_q; kp_d = kp_q; ki_d = ki_q; kd_d = kd_q;
        kvff_d = kvff_q; kaff_d = kaff_q; kdff_d = kdff_q;
        deadband_d = deadband_q; fe_limit_d = fe_limit_q;
        max_vel_d = max_vel_q; accel_d = accel_q; decel_d = decel_q;
        target_d = target_q; mask_d = mask_q;
        evt_d = evt_q;
        rdata_d = 32'h0000_0000;
        if (reg_write_i)
        begin
            case (reg_addr_i)
                servo_loop_pkg::REG_CTRL:     ctrl_d = reg_wdata_i;
                servo_loop_pkg::REG_KP:       kp_d = reg_wdata_i;
                servo_loop_pkg::REG_KI:       ki_d = reg_wdata_i;
                servo_loop_pkg::REG_KD:       kd_d = reg_wdata_i;
                servo_loop_pkg::REG_KVFF:     kvff_d = reg_wdata_i;
                servo_loop_pkg::REG_KAFF:     kaff_d = reg_wdata_i;
                servo_loop_pkg::REG_KDFF:     kdff_d = reg_wdata_i;
                servo_loop_pkg::REG_DEADBAND: deadband_d = reg_wdata_i;
                servo_loop_pkg::REG_FE_LIMIT: fe_limit_d = reg_wdata_i;
                servo_loop_pkg::REG_MAX_VEL:  max_vel_d = reg_wdata_i;
                servo_loop_pkg::REG_ACCEL:    accel_d = reg_wdata_i;
                servo_loop_pkg::REG_DECEL:    decel_d = reg_wdata_i;
                servo_loop_pkg::REG_TARGET:   target_d = reg_wdata_i;
                servo_loop_pkg::REG_IRQ_MASK: mask_d = reg_wdata_i[servo_loop_pkg::EVT_W-1:0];
                servo_loop_pkg::REG_STATUS:   evt_d = evt_q & ~reg_wdata_i[servo_loop_pkg::EVT_W-1:0];
                default:                      ;
            endcase
        end
        // Hardware sets win over a simultaneous write-one-to-clear.
        if (tick && enabled_q && fe_limit_q != 32'h0000_0000 && abs_ferr > $signed(fe_limit_q))
        begin
            evt_d[servo_loop_pkg::ST_FERR_BIT] = 1'b1;
        end
        if (tick && prof_q != servo_loop_pkg::PROF_IDLE && prof_d == servo_loop_pkg::PROF_IDLE)
        begin
            evt_d[servo_loop_pkg::ST_DONE_BIT] = 1'b1;
        end
        if (tick)
        begin
            evt_d[servo_loop_pkg::ST_SAMPLE_BIT] = 1'b1;
        end
        if (reg_read_i)
        begin
            case (reg_addr_i)
                servo_loop_pkg::REG_CTRL:     rdata_d = ctrl_q;
                servo_loop_pkg::REG_KP:       rdata_d = kp_q;
                servo_loop_pkg::REG_KI:       rdata_d = ki_q;
                servo_loop_pkg::REG_KD:       rdata_d = kd_q;
                servo_loop_pkg::REG_KVFF:     rdata_d = kvff_q;
                servo_loop_pkg::REG_KAFF:     rdata_d = kaff_q;
                servo_loop_pkg::REG_KDFF:     rdata_d = kdff_q;
                servo_loop_pkg::REG_DEADBAND: rdata_d = deadband_q;
                servo_loop_pkg::REG_FE_LIMIT: rdata_d = fe_limit_q;
                servo_loop_pkg::REG_MAX_VEL:  rdata_d = max_vel_q;
                servo_loop_pkg::REG_ACCEL:    rdata_d = accel_q;
                servo_loop_pkg::REG_DECEL:    rdata_d = decel_q;
                servo_loop_pkg::REG_TARGET:   rdata_d = target_q;
                servo_loop_pkg::REG_STATUS:
                begin
                    rdata_d[servo_loop_pkg::EVT_W-1:0] = evt_q;
                    rdata_d[servo_loop_pkg::ST_ENABLED_BIT] = enabled_q;
                    rdata_d[servo_loop_pkg::ST_MOVING_BIT] = (prof_q != servo_loop_pkg::PROF_IDLE);
                end
                servo_loop_pkg::REG_IRQ_MASK: rdata_d[servo_loop_pkg::EVT_W-1:0] = mask_q;
                servo_loop_pkg::REG_FOLLOW:   rdata_d = ferr_q;
                servo_loop_pkg::REG_DESIRED:  rdata_d = desired_q;
                servo_loop_pkg::REG_OUTPUT:   rdata_d = {16'h0000, dac_q};
                default:                      rdata_d = 32'h0000_0000;
            endcase
        end
        irq_d = |(evt_d & mask_d);
    end

    // Sample tick, trajectory and filter.
    always_comb
    begin
        tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1; // see RL1
        enabled_d = enabled_q;
        prof_d = prof_q;
        desired_d = desired_q;
        vel_d = vel_q;
        acc_cmd_d = acc_cmd_q;
        ferr_d = ferr_q;
        integ_d = integ_q;
        out_d = out_q;
        dac_d = dac_q;
        ferr_now = desired_q - $signed(encoder_pos_i); // see RL2
        abs_ferr = ferr_now[PW-1] ? -ferr_now : ferr_now;
        remain = $signed(target_q) - desired_q;
        dir = remain[PW-1] ? -32'sd1 : 32'sd1;
        // Distance needed to stop from the present speed at the deceleration rate.
        stop_dist = (decel_q == 32'h0) ? 32'sd0 :
                    PW'((64'(vel_q[PW-1] ? -vel_q : vel_q) * 64'(vel_q[PW-1] ? -vel_q : vel_q))
                        / (64'(decel_q) * 64'd2));
        pid_sum = '0;
        comp = '0;
        // A control write loads the enable bit unless a trip on the same tick clears it: a set bit re-enables the axis, and the latched error flag stays set.
        if (reg_write_i && reg_addr_i == servo_loop_pkg::REG_CTRL)
        begin
            enabled_d = reg_wdata_i[servo_loop_pkg::CTRL_ENABLE_BIT]; // see RL10
        end
        if (move_start)
        begin
            prof_d = servo_loop_pkg::PROF_ACCEL;
        end
        if (tick)
        begin
            // Trajectory step: velocity in counts per sample, rates in counts per sample squared.
            case (prof_q) // see RL4
                servo_loop_pkg::PROF_ACCEL,
                servo_loop_pkg::PROF_CRUISE:
                begin
                    if ((remain[PW-1] ? -remain : remain) <= stop_dist)
                    begin
                        prof_d = servo_loop_pkg::PROF_DECEL;
                        acc_cmd_d = -dir * $signed(decel_q);
                    end
                    else if ((vel_q[PW-1] ? -vel_q : vel_q) < $signed(max_vel_q))
                    begin
                        prof_d = servo_loop_pkg::PROF_ACCEL;
                        acc_cmd_d = dir * $signed(accel_q);
                    end
                    else
                    begin
                        prof_d = servo_loop_pkg::PROF_CRUISE;
                        acc_cmd_d = '0;
                    end
                    vel_d = vel_q + acc_cmd_d;
                    desired_d = desired_q + vel_d;
                end
                servo_loop_pkg::PROF_DECEL:
                begin
                    acc_cmd_d = -dir * $signed(decel_q);
                    vel_d = vel_q + acc_cmd_d;
                    if (remain == 0 || (vel_d[PW-1] != vel_q[PW-1]) || vel_d == 0 ||
                        (vel_q[PW-1] ? -vel_q : vel_q) >= (remain[PW-1] ? -remain : remain))
                    begin
                        prof_d = servo_loop_pkg::PROF_IDLE;
                        desired_d = $signed(target_q);
                        vel_d = '0;
                        acc_cmd_d = '0;
                    end
                    else
                    begin
                        desired_d = desired_q + vel_d;
                    end
                end
                default:
                begin
                    prof_d = servo_loop_pkg::PROF_IDLE;
                    vel_d = '0;
                    acc_cmd_d = '0;
                end
            endcase
            ferr_d = ferr_now;
            if (!ctrl_q[servo_loop_pkg::CTRL_INT_ZERO_BIT] || prof_q == servo_loop_pkg::PROF_IDLE)
            begin
                integ_d = integ_q + scale_gain(ferr_now, ki_q); // see RL7
            end
            integ_d = clamp_out(integ_d);
            pid_sum = scale_gain(ferr_now, kp_q) + integ_d
                    + scale_gain(ferr_now - ferr_q, kd_q) // see RL3
                    + scale_gain(vel_q, kvff_q) // see RL5
                    + (acc_cmd_q[PW-1] == vel_q[PW-1] ? scale_gain(acc_cmd_q, kaff_q)
                                                      : scale_gain(acc_cmd_q, kdff_q)); // see RL6
            if (pid_sum > 0)
            begin
                comp = pid_sum + AW'(deadband_q); // see RL8
            end
            else if (pid_sum < 0)
            begin
                comp = pid_sum - AW'(deadband_q); // see RL8
            end
            out_d = clamp_out(comp); // see RL11
            dac_d = out_d[15:0];
            if (fe_limit_q != 32'h0000_0000 && abs_ferr > $signed(fe_limit_q)) // see RL10
            begin
                enabled_d = 1'b0; // see RL9
            end
        end
        // The loop keeps the trajectory running but drives nothing while disabled.
        if (!enabled_q)
        begin
            integ_d = '0; // see RL12
            out_d = '0;
            dac_d = 16'h0000; // see RL9
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            ctrl_q <= servo_loop_pkg::CTRL_RESET;
            kp_q <= servo_loop_pkg::GAIN_RESET; ki_q <= servo_loop_pkg::GAIN_RESET;
            kd_q <= servo_loop_pkg::GAIN_RESET; kvff_q <= servo_loop_pkg::GAIN_RESET;
            kaff_q <= servo_loop_pkg::GAIN_RESET; kdff_q <= servo_loop_pkg::GAIN_RESET;
            deadband_q <= '0; fe_limit_q <= '0;
            max_vel_q <= '0; accel_q <= '0; decel_q <= '0; target_q <= '0;
            evt_q <= '0; mask_q <= '0; rdata_q <= '0; irq_q <= 1'b0;
            enabled_q <= 1'b0; tick_cnt_q <= '0; prof_q <= servo_loop_pkg::PROF_IDLE;
            desired_q <= '0; vel_q <= '0; acc_cmd_q <= '0; ferr_q <= '0;
            integ_q <= '0; out_q <= '0; dac_q <= 16'h0000;
        end
        else
        begin
            ctrl_q <= ctrl_d; kp_q <= kp_d; ki_q <= ki_d; kd_q <= kd_d;
            kvff_q <= kvff_d; kaff_q <= kaff_d; kdff_q <= kdff_d;
            deadband_q <= deadband_d; fe_limit_q <= fe_limit_d;
            max_vel_q <= max_vel_d; accel_q <= accel_d; decel_q <= decel_d;
            target_q <= target_d;
            evt_q <= evt_d; mask_q <= mask_d; rdata_q <= rdata_d; irq_q <= irq_d;
            enabled_q <= enabled_d; tick_cnt_q <= tick_cnt_d; prof_q <= prof_d;
            desired_q <= desired_d; vel_q <= vel_d; acc_cmd_q <= acc_cmd_d;
            ferr_q <= ferr_d; integ_q <= integ_d; out_q <= out_d; dac_q <= dac_d;
        end
    end

    assign reg_rdata_o   = rdata_q;
    assign dac_command_o = dac_q;
    assign amp_enable_o  = enabled_q;
    assign irq_o         = irq_q;

endmodule : servo_pid_position_loop

// file: verilog/servo_loop_pkg.sv
// Constants shared by the servo position loop and its bench.
// Assumes a single 40 MHz system clock and a synchronous active high reset.
package servo_loop_pkg;

    localparam int unsigned CLK_HZ          = 40000000;
    localparam int unsigned SAMPLE_US       = 250;
    localparam int unsigned SAMPLE_CYCLES   = (CLK_HZ / 1000000) * SAMPLE_US;
    localparam int unsigned SAMPLE_CNT_W    = 14;

    localparam int unsigned POS_W           = 32;
    localparam int unsigned GAIN_W          = 16;
    localparam int unsigned GAIN_FRAC       = 8;
    localparam int unsigned DAC_W           = 16;
    localparam int unsigned ACC_W           = 48;

    // Command code range maps onto +10 V ... -10 V of the analog output.
    localparam logic signed [DAC_W-1:0] DAC_MAX = 16'sh7fff;
    localparam logic signed [DAC_W-1:0] DAC_MIN = -16'sh7fff;

    // Register offsets, one word each.
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_KP        = 8'h04;
    localparam logic [7:0] REG_KI        = 8'h08;
    localparam logic [7:0] REG_KD        = 8'h0c;
    localparam logic [7:0] REG_KVFF      = 8'h10;
    localparam logic [7:0] REG_KAFF      = 8'h14;
    localparam logic [7:0] REG_KDFF      = 8'h18;
    localparam logic [7:0] REG_DEADBAND  = 8'h1c;
    localparam logic [7:0] REG_FE_LIMIT  = 8'h20;
    localparam logic [7:0] REG_MAX_VEL   = 8'h24;
    localparam logic [7:0] REG_ACCEL     = 8'h28;
    localparam logic [7:0] REG_DECEL     = 8'h2c;
    localparam logic [7:0] REG_TARGET    = 8'h30;
    localparam logic [7:0] REG_STATUS    = 8'h34;
    localparam logic [7:0] REG_IRQ_MASK  = 8'h38;
    localparam logic [7:0] REG_FOLLOW    = 8'h3c;
    localparam logic [7:0] REG_DESIRED   = 8'h40;
    localparam logic [7:0] REG_OUTPUT    = 8'h44;

    // Control register fields.
    localparam int unsigned CTRL_ENABLE_BIT   = 0;
    localparam int unsigned CTRL_INT_ZERO_BIT = 1;

    // Status register fields; bits 0..2 are sticky events.
    localparam int unsigned ST_FERR_BIT       = 0;
    localparam int unsigned ST_DONE_BIT       = 1;
    localparam int unsigned ST_SAMPLE_BIT     = 2;
    localparam int unsigned ST_ENABLED_BIT    = 8;
    localparam int unsigned ST_MOVING_BIT     = 9;
    localparam int unsigned EVT_W             = 3;

    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] GAIN_RESET  = 32'h0000_0000;

    typedef enum logic [1:0] {
        PROF_IDLE,
        PROF_ACCEL,
        PROF_CRUISE,
        PROF_DECEL
    } prof_state_e;

endpackage : servo_loop_pkg

// file: verif/servo_loop_checker.sv
// Concurrent checks on the servo position loop, seeing only its top-level ports.
// Assumes the sample tick period is SAMPLE_CYCLES counted from reset release.
module servo_loop_checker (
    input wire logic        clk_sys_i,
    input wire logic        reset_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_write_i,
    input wire logic        reg_read_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [31:0] encoder_pos_i,
    input wire logic [15:0] dac_command_o,
    input wire logic        amp_enable_o,
    input wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int P = servo_loop_pkg::SAMPLE_CYCLES;
    logic [13:0] ph_q;
    logic [13:0] ph_d;
    logic        near;
    // The phase only brackets the tick; a few cycles of slack absorb which edge counts first.
    always_comb
    begin
        ph_d = (ph_q == 14'(P - 1)) ? 14'h0 : ph_q + 14'h1;
    end
    always_ff @(posedge clk_sys_i)
    begin
        ph_q <= reset_i ? 14'h0 : ph_d;
    end
    assign near = (ph_q <= 14'h5) || (ph_q >= 14'(P - 6));
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    chk_dac_on_tick: assert property ($changed(dac_command_o) && amp_enable_o |-> near)
        else $error("command changed away from a sample tick");
    chk_dac_range: assert property (dac_command_o != 16'h8000)
        else $error("command beyond the symmetric range");
    chk_fault_dac_zero: assert property ($fell(amp_enable_o) |=> dac_command_o == 16'h0)
        else $error("command not zero after the axis dropped");
    chk_off_dac_zero: assert property (!amp_enable_o && !$past(amp_enable_o) |->
        dac_command_o == 16'h0) else $error("command nonzero while disabled");
    chk_amp_fall_cause: assert property ($fell(amp_enable_o) |-> near ||
        $past(reg_write_i) || $past(reg_write_i, 2)) else $error("amplifier dropped uncaused");
    chk_amp_rise_cause: assert property ($rose(amp_enable_o) |->
        $past(reg_write_i && reg_addr_i == servo_loop_pkg::REG_CTRL && reg_wdata_i[0]) ||
        $past(reg_write_i && reg_addr_i == servo_loop_pkg::REG_CTRL && reg_wdata_i[0], 2))
        else $error("amplifier enabled without a control write");
    chk_irq_cause: assert property ($changed(irq_o) |-> near ||
        $past(reg_write_i) || $past(reg_write_i, 2)) else $error("interrupt moved uncaused");
    chk_rdata_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside its cycle");
    chk_rdata_unmapped: assert property (reg_read_i && reg_addr_i == 8'hfc |=>
        reg_rdata_o == 32'h0) else $error("unmapped read not zero");
    cover property ($fell(amp_enable_o));
    cover property ($rose(irq_o));
    cover property (dac_command_o == 16'h8001);
endmodule : servo_loop_checker

bind servo_pid_position_loop servo_loop_checker chk (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .encoder_pos_i(encoder_pos_i),
    .dac_command_o(dac_command_o), .amp_enable_o(amp_enable_o), .irq_o(irq_o));

// file: verif/servo_plant_model.sv
// Behavioural amplifier, motor and encoder standing at the far side of the loop.
// Assumes the same system clock; the bench sets the encoder offset and lets the motor run.
module servo_plant_model (
    input  wire logic        clk_sys_i,
    input  wire logic        plant_on_i,
    input  wire logic        amp_enable_i,
    input  wire logic [15:0] dac_command_i,
    input  wire logic [31:0] offset_i,
    output logic      [31:0] encoder_pos_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic signed [47:0] acc_q;
    // A positive command moves the shaft towards positive counts; a held plant stays put.
    always_ff @(posedge clk_sys_i)
    begin
        if (!plant_on_i)
            acc_q <= '0;
        else if (amp_enable_i)
            acc_q <= acc_q + $signed(dac_command_i);
    end
    assign encoder_pos_o = offset_i + 32'(acc_q >>> 16);
endmodule : servo_plant_model

// file: verif/tb_servo_pid_position_loop.sv
// Self-checking bench for the servo position loop with a behavioural plant.
// Assumes no trajectory move is started before the last test, so the desired position stays at zero until then.
module tb_servo_pid_position_loop;
    timeunit 1ns;
    timeprecision 100ps;
    logic               clk_sys_i = 1'b0;
    logic               reset_i = 1'b1;
    logic               reg_write_i = 1'b0;
    logic               reg_read_i = 1'b0;
    logic               plant_on = 1'b0;
    logic [7:0]         reg_addr_i = 8'h0;
    logic [31:0]        reg_wdata_i = 32'h0;
    logic [31:0]        enc_offset = 32'h0;
    logic [31:0]        reg_rdata_o, encoder_pos_i, rd;
    logic [15:0]        dac_command_o, kp;
    logic [15:0]        seed = 16'h0046;
    logic               amp_enable_o, irq_o;
    logic signed [31:0] enc, f2;
    logic signed [31:0] tbl [2] = '{32'sd40, -32'sd30};
    int                 num_errors = 0;
    int                 num_checks = 0;

    servo_pid_position_loop dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
        .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .encoder_pos_i(encoder_pos_i),
        .dac_command_o(dac_command_o), .amp_enable_o(amp_enable_o), .irq_o(irq_o));
    servo_plant_model plant (.clk_sys_i(clk_sys_i), .plant_on_i(plant_on),
        .amp_enable_i(amp_enable_o), .dac_command_i(dac_command_o), .offset_i(enc_offset),
        .encoder_pos_o(encoder_pos_i));

    initial
    begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // Expected command with only the proportional term active, desired position zero.
    function automatic logic [15:0] exp_dac(input longint ferr, input longint g, input longint db);
        longint t;
        t = (ferr * g) >>> 8;
        if (t > 0)
            t = t + db;
        else if (t < 0)
            t = t - db;
        if (t > 32767)
            t = 32767;
        if (t < -32767)
            t = -32767;
        return t[15:0];
    endfunction : exp_dac

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_write_i <= 1'b0;
    endtask : wr

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_read_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rd_reg

    // Waits on the sample interrupt, so the mask and sticky status are exercised every tick.
    task automatic tick();
        int n;
        wr(servo_loop_pkg::REG_STATUS, 32'h7);
        repeat (2) @(posedge clk_sys_i);
        n = 0;
        while (irq_o !== 1'b1 && n < 12000)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= 12000)
        begin
            num_errors++;
            $display("wrong value at %0t: no sample tick", $time);
            report_and_stop();
        end
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask : tick

    initial
    begin
        repeat (16) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rd_reg(servo_loop_pkg::REG_KP, rd);
        check_word(rd, servo_loop_pkg::GAIN_RESET);
        rd_reg(8'hfc, rd);
        check_word(rd, 32'h0);
        wr(servo_loop_pkg::REG_KP, 32'h100);
        wr(servo_loop_pkg::REG_DEADBAND, 32'h5);
        wr(servo_loop_pkg::REG_IRQ_MASK, 32'h4);
        wr(servo_loop_pkg::REG_CTRL, 32'h1);
        $display("test setup done");
        foreach (tbl[i])
        begin
            @(posedge clk_sys_i) enc_offset <= tbl[i];
            tick();
            check_word({16'h0, dac_command_o}, {16'h0, exp_dac(-tbl[i], 256, 5)});
            rd_reg(servo_loop_pkg::REG_FOLLOW, rd);
            check_word(rd, -tbl[i]);
        end
        wr(servo_loop_pkg::REG_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk_sys_i);
        check_word({31'h0, irq_o}, 32'h0);
        wr(servo_loop_pkg::REG_IRQ_MASK, 32'h4);
        repeat (2) @(posedge clk_sys_i);
        check_word({31'h0, irq_o}, 32'h1);
        $display("test direction done");
        wr(servo_loop_pkg::REG_FE_LIMIT, 32'd20);
        wr(servo_loop_pkg::REG_IRQ_MASK, 32'h5);
        @(posedge clk_sys_i) enc_offset <= 32'd50;
        tick();
        check_word({31'h0, amp_enable_o}, 32'h0);
        check_word({16'h0, dac_command_o}, 32'h0);
        rd_reg(servo_loop_pkg::REG_STATUS, rd);
        check_word({31'h0, rd[servo_loop_pkg::ST_FERR_BIT]}, 32'h1);
        wr(servo_loop_pkg::REG_FE_LIMIT, 32'h0);
        wr(servo_loop_pkg::REG_IRQ_MASK, 32'h4);
        wr(servo_loop_pkg::REG_CTRL, 32'h1);
        repeat (3) @(posedge clk_sys_i);
        check_word({31'h0, amp_enable_o}, 32'h1);
        $display("test fault done");
        @(posedge clk_sys_i) enc_offset <= 32'd50000;
        tick();
        check_word({16'h0, dac_command_o}, 32'h8001);
        repeat (2)
        begin
            seed = lfsr(seed);
            kp = seed & 16'h03ff;
            seed = lfsr(seed);
            enc = $signed({21'h0, seed[10:0]}) - 32'sd1024;
            wr(servo_loop_pkg::REG_KP, {16'h0, kp});
            @(posedge clk_sys_i) enc_offset <= enc;
            tick();
            check_word({16'h0, dac_command_o}, {16'h0, exp_dac(-enc, kp, 5)});
        end
        $display("test random done");
        wr(servo_loop_pkg::REG_KP, 32'h100);
        @(posedge clk_sys_i) enc_offset <= 32'd40;
        tick();
        @(posedge clk_sys_i) plant_on <= 1'b1;
        tick();
        rd_reg(servo_loop_pkg::REG_FOLLOW, rd);
        f2 = rd;
        check_word({31'h0, f2 > -32'sd40 && f2 < 32'sd0}, 32'h1);
        $display("test closed loop done");
        // One sample into a move from rest, the desired position has advanced by one acceleration step.
        wr(servo_loop_pkg::REG_ACCEL, 32'd3);
        wr(servo_loop_pkg::REG_MAX_VEL, 32'd100);
        wr(servo_loop_pkg::REG_DECEL, 32'd3);
        wr(servo_loop_pkg::REG_TARGET, 32'd1000);
        tick();
        rd_reg(servo_loop_pkg::REG_DESIRED, rd);
        check_word(rd, 32'd3);
        $display("test move done");
        report_and_stop();
    end
endmodule : tb_servo_pid_position_loop
